// ==== hdl/floppy_drive_motor_control_regs.sv ====
// Implementation choices: the placing of the registers and the plain strobed port.
`include "fdc_motor_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module floppy_drive_motor_control_regs (
  input  wire logic                       mclk,
  input  wire logic                       reset,
  input  wire fdc_motor_pkg::bus_req_t    bus_req,
  output fdc_motor_pkg::bus_rsp_t         bus_rsp,
  input  wire logic [1:0]                 media_sense,
  input  wire logic [7:0]                 drive_id_table,
  output fdc_motor_pkg::drive_pins_t      drive_pins,
  output logic                            soft_reset,
  output logic                            dma_irq_enable,
  output logic                            request_oe,
  output logic [1:0]                      tape_drive,
  output logic                            setup_clear
);
  import fdc_motor_pkg::*;

  logic [7:0] drive_output_control;
  logic [7:0] media_drive_type;
  logic [7:0] config_control_reg;
  logic [1:0] sense_meta;
  logic [1:0] sense_sync;
  logic       soft_reset_q;
  logic [3:0] next_motor;
  logic [3:0] next_select;
  logic [7:0] next_rdata;
  logic [7:0] next_oe;
  logic       four_drive;
  logic       alt_mode;
  logic       enhanced;
  exch_t      exch;

  assign four_drive = config_control_reg[`CFG_FOUR_BIT];
  assign alt_mode   = config_control_reg[`CFG_ALT_BIT];
  assign enhanced   = config_control_reg[`CFG_LAYOUT_BIT];
  assign exch       = exch_t'(media_drive_type[3:2]);

  // media sense pins come from the drive cable, so synchronise first
  always_ff @(posedge mclk) begin
    if (reset) begin
      sense_meta <= 2'h0;
      sense_sync <= 2'h0;
    end else begin
      sense_meta <= media_sense;
      sense_sync <= sense_meta;
    end
  end

  // output register: only hardware reset clears it, soft reset is a bit of it
  always_ff @(posedge mclk) begin
    if (reset) begin
      drive_output_control <= `DOC_RESET_VAL;
    end else if (bus_req.wr && bus_req.addr == `DOC_OFFSET) begin
      drive_output_control <= bus_req.wdata;
    end
  end

  // type register; stores every written bit, legacy layout reads show only tape select, drive 0 never a tape
  always_ff @(posedge mclk) begin
    if (reset) begin
      media_drive_type <= `MDT_RESET_VAL;
    end else if (bus_req.wr && bus_req.addr == `MDT_OFFSET) begin
      media_drive_type <= bus_req.wdata;
    end
  end

  // configuration: four-drive, layout and mode select; soft reset leaves it
  always_ff @(posedge mclk) begin
    if (reset) begin
      config_control_reg <= `CFG_RESET_VAL;
    end else if (bus_req.wr && bus_req.addr == `CFG_OFFSET) begin
      config_control_reg <= bus_req.wdata;
    end
  end

  // soft reset level and a one-cycle pulse clearing setup/mode state on entry;
  // software owns the minimum low time; nothing here counts SRST_MIN_CYC, and two back-to-back writes fall short of it
  always_ff @(posedge mclk) begin
    if (reset) begin
      soft_reset_q <= 1'b1;
      setup_clear  <= 1'b1;
    end else begin
      soft_reset_q <= ~drive_output_control[`DOC_RESET_BIT];
      setup_clear  <= ~drive_output_control[`DOC_RESET_BIT] & ~soft_reset_q;
    end
  end
  assign soft_reset = soft_reset_q;

  // dma/irq gating: alternate mode ignores the gate bit and stays enabled
  always_ff @(posedge mclk) begin
    if (reset) begin
      dma_irq_enable <= 1'b0;
      request_oe     <= 1'b0;
    end else begin
      dma_irq_enable <= alt_mode | drive_output_control[`DOC_DMA_BIT];
      request_oe     <= alt_mode | drive_output_control[`DOC_DMA_BIT];
    end
  end

  // motor and select decode; select pattern outside the table selects no drive, motor bits still pass
  always_comb begin
    logic [3:0] men;
    logic [1:0] sel;
    men         = drive_output_control[7:4];
    sel         = drive_output_control[1:0];
    next_motor  = 4'h0;
    next_select = 4'h0;
    if (four_drive) begin
      next_select[sel] = 1'b1;
      next_motor[sel]  = men[sel];
    end else begin
      next_motor[1:0] = men[1:0];
      if (exch == exch_02 && enhanced) begin
        next_motor[2] = men[0];
        next_motor[0] = men[2];
        if (sel == 2'h0) next_select[2] = 1'b1;
        else if (sel == 2'h2) next_select[0] = 1'b1;
        else if (sel == 2'h1) next_select[1] = 1'b1;
      end else if (exch == exch_01 && enhanced) begin
        next_motor[0] = men[1];
        next_motor[1] = men[0];
        if (sel == 2'h0) next_select[1] = 1'b1;
        else if (sel == 2'h1) next_select[0] = 1'b1;
      end else if (sel[1] == 1'b0) begin
        next_select[sel] = 1'b1;
      end
    end
  end

  // pins follow the register on the edge after the write
  always_ff @(posedge mclk) begin
    if (reset) begin
      drive_pins <= '0;
      tape_drive <= 2'h0;
    end else begin
      drive_pins.motor     <= next_motor;
      drive_pins.drive_sel <= next_select;
      tape_drive           <= media_drive_type[1:0];
    end
  end

  // read mux; legacy type reads float bits 7-2
  always_comb begin
    next_rdata = 8'h00;
    next_oe    = 8'hFF;
    unique case (bus_req.addr)
      `DOC_OFFSET: next_rdata = drive_output_control;
      `MDT_OFFSET: begin
        if (enhanced) begin
          next_rdata = {sense_sync[1], sense_sync[0],
                        drive_id_table[{drive_output_control[0], 1'b1}],
                        drive_id_table[{drive_output_control[0], 1'b0}],
                        media_drive_type[3:0]};
        end else begin
          next_rdata = {6'h00, media_drive_type[1:0]};
          next_oe    = 8'h03;
        end
      end
      `CFG_OFFSET:  next_rdata = config_control_reg;
      `STAT_OFFSET: next_rdata = {next_motor, 2'h0, request_oe, soft_reset_q};
      default:      next_rdata = 8'h00;
    endcase
  end

  // read data stand only in the cycle after the read strobe
  always_ff @(posedge mclk) begin
    if (reset) begin
      bus_rsp <= '0;
    end else if (bus_req.rd) begin
      bus_rsp.rdata    <= next_rdata;
      bus_rsp.rdata_oe <= next_oe;
    end else begin
      bus_rsp <= '0;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/fdc_motor_regs.svh ====
`ifndef FDC_MOTOR_REGS_SVH
`define FDC_MOTOR_REGS_SVH
// Operation
// - writing 0 to output bit 2 holds controller in reset until 1 written.
// - soft reset clears setup and mode settings, keeps rate, config, other bits.
// - legacy mode: bit 3 enables dma and irq; 0 disables, floats request lines.
// - legacy mode: dma gate bit is cleared by reset.
// - alternate mode: dma gate reserved, dma and irq always enabled, even in reset.
// - bit 4 drives motor 0 in two-drive mode; decoded in four-drive mode.
// - bit 5 drives motor 1 in two-drive mode; decoded in four-drive mode.
// - bit 6 drives motor 2 when drives 2 and 0 exchanged or four drives.
// - bit 7 drives motor 3 in four-drive mode through the decode.
// - motor enable 1 makes motor active, 0 inactive.
// - type register is read/write; config bit 6 picks legacy or enhanced layout.
// - legacy layout assigns one logical drive to tape mode, rest floppy.
// - legacy layout reads leave bits 7-2 undriven.
// - enhanced layout uses all bits: density, id, exchange, drive select.
// - output bits 1:0 select one drive; 2 and 3 need four-drive or exchange.
// - hardware reset clears output register; soft reset leaves it.
// - tape select never names drive 0; 00 means none.

// register offsets (plain port address)
`define DOC_OFFSET      3'h2
`define MDT_OFFSET      3'h3
`define CFG_OFFSET      3'h4
`define STAT_OFFSET     3'h5
// output register fields, with the output and type register reset values
`define DOC_RESET_BIT   2
`define DOC_DMA_BIT     3
`define DOC_MOTOR_LSB   4
`define DOC_RESET_VAL   8'h00
`define MDT_RESET_VAL   8'h00
// config register fields
`define CFG_FOUR_BIT    7
`define CFG_LAYOUT_BIT  6
`define CFG_ALT_BIT     0
`define CFG_RESET_VAL   8'h00
// timing
`define SRST_MIN_NS     100
`define CLK_PERIOD_NS   8
`define SRST_MIN_CYC    ((`SRST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ==== hdl/fdc_motor_pkg.sv ====
package fdc_motor_pkg;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;
  typedef struct packed {
    logic [7:0] rdata;
    logic [7:0] rdata_oe;
  } bus_rsp_t;
  typedef struct packed {
    logic [3:0] motor;
    logic [3:0] drive_sel;
  } drive_pins_t;
  typedef enum logic [1:0] { exch_none, exch_01, exch_02, exch_rsvd } exch_t;
endpackage

// ==== bench/fdc_motor_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
module fdc_motor_chk (
  input wire logic                       mclk,
  input wire logic                       reset,
  input wire fdc_motor_pkg::bus_req_t    bus_req,
  input wire fdc_motor_pkg::bus_rsp_t    bus_rsp,
  input wire fdc_motor_pkg::drive_pins_t drive_pins,
  input wire logic                       soft_reset,
  input wire logic                       dma_irq_enable,
  input wire logic                       setup_clear
);
  import fdc_motor_pkg::*;
  logic [7:0] cfg;
  logic [7:0] doc;
  // write decode and the expected pin patterns of the written byte
  wire logic dw = bus_req.wr && bus_req.addr == 3'h2;
  wire logic ds = dw && bus_req.wdata[2];
  wire logic [3:0] s4 = 4'h1 << bus_req.wdata[1:0];
  wire logic [3:0] s2 = bus_req.wdata[1] ? 4'h0 : s4;
  wire logic [3:0] m4 = bus_req.wdata[{1'h1, bus_req.wdata[1:0]}] ? s4 : 4'h0;
  // config shadow, needed because drive count and layout are not on the ports
  always_ff @(posedge mclk) begin
    if (reset)
      cfg <= 8'h00;
    else if (bus_req.wr && bus_req.addr == 3'h4)
      cfg <= bus_req.wdata;
  end
  // output register shadow; only a hardware reset clears it
  always_ff @(posedge mclk) begin
    if (reset)
      doc <= 8'h00;
    else if (dw)
      doc <= bus_req.wdata;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence rd_of(a);
    bus_req.rd && bus_req.addr == a;
  endsequence
  chk_enter_reset: assert property (dw && !bus_req.wdata[2] |-> ##2 soft_reset)
    else $error("soft reset not entered");
  chk_leave_reset: assert property ($fell(soft_reset) |-> $past(ds, 2))
    else $error("soft reset left without write");
  chk_hw_clear: assert property (disable iff (1'h0) reset |=>
      soft_reset && !dma_irq_enable && drive_pins == '0) else $error("hw reset state");
  chk_dma_gate: assert property (dw && !cfg[0] |-> ##2
      dma_irq_enable == $past(bus_req.wdata[3], 2)) else $error("dma gate");
  chk_alt_dma: assert property (cfg[0] && $past(cfg[0], 2) |-> dma_irq_enable)
    else $error("dma off in alternate mode");
  chk_two_drive: assert property (dw && cfg[7:6] == 2'h0 |-> ##2
      drive_pins == {2'h0, $past(bus_req.wdata[5:4], 2), $past(s2, 2)}) else $error("pins 2");
  chk_four_drive: assert property (dw && cfg[7] |-> ##2
      drive_pins == {$past(m4, 2), $past(s4, 2)}) else $error("pins 4");
  chk_doc_read: assert property (rd_of(3'h2) |=> bus_rsp.rdata == doc)
    else $error("output register readback");
  chk_type_float: assert property (rd_of(3'h3) ##0 !cfg[6] |=> bus_rsp.rdata_oe == 8'h03)
    else $error("type register upper bits driven");
  // setup state is cleared once, on the cycle the controller enters soft reset
  chk_setup_pulse: assert property ($rose(soft_reset) |-> setup_clear ##1 !setup_clear)
    else $error("setup clear pulse missing");
endmodule
bind floppy_drive_motor_control_regs fdc_motor_chk chk (.mclk(mclk), .reset(reset),
  .bus_req(bus_req), .bus_rsp(bus_rsp), .drive_pins(drive_pins),
  .soft_reset(soft_reset), .dma_irq_enable(dma_irq_enable), .setup_clear(setup_clear));
`default_nettype wire

// ==== bench/fdc_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module fdc_host (
  input  wire logic                    mclk,
  input  wire fdc_motor_pkg::bus_rsp_t bus_rsp,
  output fdc_motor_pkg::bus_req_t      bus_req
);
  import fdc_motor_pkg::*;
  initial bus_req = '0;
  // one-cycle write strobe beside address and data
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_req <= '{a, d, 1'h1, 1'h0};
    @(posedge mclk);
    bus_req <= '0;
  endtask
  // data stands only in the cycle after the strobe, so take it mid-cycle
  task automatic rd(input logic [2:0] a, output bus_rsp_t r);
    @(posedge mclk);
    bus_req <= '{a, 8'h00, 1'h0, 1'h1};
    @(posedge mclk);
    bus_req <= '0;
    @(negedge mclk);
    r = bus_rsp;
  endtask
endmodule
`default_nettype wire

// ==== bench/test_floppy_drive_motor_control_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_floppy_drive_motor_control_regs;
  import fdc_motor_pkg::*;
  logic        mclk = 1'h0;
  logic        reset = 1'h1;
  bus_req_t    bus_req;
  bus_rsp_t    bus_rsp;
  bus_rsp_t    r;
  drive_pins_t drive_pins;
  logic        soft_reset;
  logic        dma_irq_enable;
  logic        request_oe;
  logic        setup_clear;
  logic [1:0]  tape_drive;
  logic [1:0]  media_sense = 2'h2;
  logic [7:0]  drive_id_table = 8'hE4;
  int          errors = 0;
  int          checked = 0;
  fdc_host host (.mclk(mclk), .bus_rsp(bus_rsp), .bus_req(bus_req));
  floppy_drive_motor_control_regs uut (.mclk(mclk), .reset(reset), .bus_req(bus_req),
    .bus_rsp(bus_rsp), .media_sense(media_sense), .drive_id_table(drive_id_table),
    .drive_pins(drive_pins), .soft_reset(soft_reset), .dma_irq_enable(dma_irq_enable),
    .request_oe(request_oe), .tape_drive(tape_drive), .setup_clear(setup_clear));
  initial forever #4 mclk = ~mclk;
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // pins move two edges after the write, so look one cycle after the write returns
  task automatic wp(input logic [7:0] d, input logic [7:0] ep, input logic [2:0] ec);
    host.wr(3'h2, d);
    @(posedge mclk);
    @(negedge mclk);
    cmp("drive_pins", ep, drive_pins);
    cmp("control", {5'h00, ec}, {5'h00, soft_reset, dma_irq_enable, request_oe});
  endtask
  task automatic rv(input logic [2:0] a, input logic [7:0] e, input logic [7:0] eo);
    host.rd(a, r);
    cmp("rdata", e, r.rdata);
    cmp("rdata_oe", eo, r.rdata_oe);
  endtask
  task automatic complete_run;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // the tests need about 75 cycles; this leaves ample margin
  initial begin
    #8000;
    errors++;
    complete_run;
  end
  initial begin
    repeat (6) @(posedge mclk);
    reset <= 1'h0;
    rv(3'h2, 8'h00, 8'hFF);
    cmp("control", 8'h04, {5'h00, soft_reset, dma_irq_enable, request_oe});
    wp(8'h3D, 8'h32, 3'h3);
    wp(8'h39, 8'h32, 3'h7);
    rv(3'h2, 8'h39, 8'hFF);
    wp(8'h3D, 8'h32, 3'h3);
    wp(8'h54, 8'h11, 3'h0);
    wp(8'h4E, 8'h00, 3'h3);
    host.wr(3'h4, 8'h80);
    for (int i = 0; i < 4; i++)
      wp({4'h1 << i, 4'hC | 4'(i)}, {4'h1 << i, 4'h1 << i}, 3'h3);
    wp(8'h7F, 8'h08, 3'h3);
    host.wr(3'h4, 8'h00);
    for (int i = 0; i < 4; i++) begin
      host.wr(3'h3, {6'h3F, 2'(i)});
      rv(3'h3, {6'h00, 2'(i)}, 8'h03);
      cmp("tape_drive", 8'(i), {6'h00, tape_drive});
    end
    host.wr(3'h4, 8'h40);
    host.wr(3'h3, 8'h05);
    rv(3'h3, 8'h95, 8'hFF);
    host.wr(3'h4, 8'h01);
    wp(8'h00, 8'h01, 3'h7);
    host.wr(3'h7, 8'hFF);
    rv(3'h7, 8'h00, 8'hFF);
    complete_run;
  end
endmodule
`default_nettype wire
